/* File: fscr_defines.svh */
/*
 * constants for the floating-point status/control and identification registers:
 * system register selectors, field positions, reset values.
 * assumes inclusion by bare name from the package; the design module uses the macros through it.
 */
`ifndef FSCR_DEFINES_SVH
`define FSCR_DEFINES_SVH

// ----------------------------------------------------------------------
// system register selectors
// ----------------------------------------------------------------------
`define FSCR_SEL_ID       4'h0
`define FSCR_SEL_SC       4'h1
`define FSCR_SEL_EN       4'h8

// ----------------------------------------------------------------------
// status and control fields
// ----------------------------------------------------------------------
`define FSCR_B_LT         31
`define FSCR_B_EQ         30
`define FSCR_B_CARRY      29
`define FSCR_B_UNORD      28
`define FSCR_B_HALF       26
`define FSCR_B_DNAN       25
`define FSCR_B_FLUSH      24
`define FSCR_RM_HI        23
`define FSCR_RM_LO        22
`define FSCR_STEP_HI      21
`define FSCR_STEP_LO      20
`define FSCR_CNT_HI       18
`define FSCR_CNT_LO       16
`define FSCR_B_DENORM     7
`define FSCR_B_INEXACT    4
`define FSCR_WMASK        32'hF7F7_009F
`define FSCR_RESET        32'h0000_0000

// ----------------------------------------------------------------------
// enable register fields
// ----------------------------------------------------------------------
`define FSCR_B_UEN        30
`define FSCR_B_VTRAP      29

// ----------------------------------------------------------------------
// identification fields, values arbitrary
// ----------------------------------------------------------------------
`define FSCR_ID_IMPL      8'h5A
`define FSCR_ID_EMUL      1'b0
`define FSCR_ID_SUBARCH   7'h03
`define FSCR_ID_PART      8'h30
`define FSCR_ID_VARIANT   4'h1
`define FSCR_ID_REV       4'h0

`endif

/* File: fscr_pkg.sv */
/*
 * types shared by the floating-point system register bank.
 * assumes fscr_defines.svh is on the include path.
 */
package fscr_pkg;
   `include "fscr_defines.svh"

   typedef enum logic [1:0] {
      FSCR_RND_NEAREST = 2'h0,
      FSCR_RND_PLUS    = 2'h1,
      FSCR_RND_MINUS   = 2'h2,
      FSCR_RND_ZERO    = 2'h3
   } fscr_round_t;

   typedef struct packed {
      logic [31:0] sc;
      logic        unit_en;
      logic        vtrap;
      logic [31:0] rdata;
      logic        rvalid;
      logic        fault;
      logic        undef;
      logic        op_go;
      logic [3:0]  rnd_oh;
      logic        ftz_scalar;
      logic        ftz_simd;
      logic        half_sel;
      logic        dnan;
      logic [5:0]  flags;
   } fscr_state_t;
endpackage

/* File: fscr_regs.sv */
/*
 * floating-point system register bank: identification, status/control and enable.
 * assumes a host core in the same clock domain issuing one-cycle move strobes,
 * and an arithmetic datapath issuing one-cycle result and exception strobes.
 */
// Overview of operation
// - compare less-than sets bit 31
// - compare equal sets bit 30
// - equal, greater or unordered sets bit 29
// - unordered compare sets bit 28
// - bit 26 picks half-precision format
// - bit 25 enables default NaN
// - bit 24 enables scalar flush-to-zero
// - packed SIMD always flushes denormals
// - bits 23:22 hold rounding mode
// - step and count kept for legacy
// - nonzero count traps data-processing instructions
// - sticky flags at bits 7, 4:0
// - sticky flags driven on export bus
// - identification read only when privileged
// - identification field layout
// - bit 23 marks full hardware
// - status/control open to all modes
// - enable resets zero, gates status access
// - status/control readable and writable by moves
// - 32-bit registers, reserved read zero
`timescale 1ns/100ps
module fscr_regs
   import fscr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // host core system register moves
   input  wire logic        mv_rd,
   input  wire logic        mv_wr,
   input  wire logic [3:0]  mv_sel,
   input  wire logic        mv_priv,
   input  wire logic [31:0] mv_wdata,
   output logic [31:0]      mv_rdata,
   output logic             mv_rvalid,
   output logic             mv_fault,
   // comparison result
   input  wire logic        cmp_valid,
   input  wire logic        cmp_lt,
   input  wire logic        cmp_eq,
   input  wire logic        cmp_unord,
   // arithmetic exceptions and issue
   input  wire logic        exc_valid,
   input  wire logic [5:0]  exc_flags,
   input  wire logic        dp_issue,
   output logic             dp_undef,
   output logic             dp_go,
   // datapath controls
   output logic [3:0]       round_onehot,
   output logic             ftz_scalar,
   output logic             ftz_simd,
   output logic             alt_half_precision_sel,
   output logic             default_nan_mode,
   output logic [5:0]       fp_flag_export_bus
);

   fscr_state_t s_q;
   fscr_state_t s_d;
   logic [31:0] id_word;
   logic        sc_ok;
   logic [2:0]  cnt;
   logic [5:0]  flag_bits;
   logic [5:0]  flag_wr;

   // ----------------------------------------------------------------------
   // identification word
   // ----------------------------------------------------------------------
   assign id_word = {`FSCR_ID_IMPL, `FSCR_ID_EMUL, `FSCR_ID_SUBARCH,
                     `FSCR_ID_PART, `FSCR_ID_VARIANT, `FSCR_ID_REV};

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;
      s_d.fault  = 1'b0;
      s_d.undef  = 1'b0;
      s_d.op_go  = 1'b0;
      sc_ok      = s_q.unit_en;
      cnt        = s_q.sc[`FSCR_CNT_HI:`FSCR_CNT_LO];
      flag_bits  = {s_q.sc[`FSCR_B_DENORM], s_q.sc[`FSCR_B_INEXACT:0]};
      flag_wr    = {mv_wdata[`FSCR_B_DENORM], mv_wdata[`FSCR_B_INEXACT:0]};

      // software write first, so hardware sets below win in the same cycle
      if (mv_wr) begin
         case (mv_sel)
            `FSCR_SEL_SC: begin
               if (sc_ok) begin
                  s_d.sc = mv_wdata & `FSCR_WMASK;
                  flag_bits = flag_wr;
               end else begin
                  s_d.fault = 1'b1;
               end
            end
            `FSCR_SEL_EN: begin
               if (mv_priv) begin
                  s_d.unit_en = mv_wdata[`FSCR_B_UEN];
                  s_d.vtrap   = mv_wdata[`FSCR_B_VTRAP];
               end else begin
                  s_d.fault = 1'b1;
               end
            end
            `FSCR_SEL_ID: s_d.fault = 1'b0; // write ignored
            default:      s_d.fault = 1'b0; // reserved ignores writes
         endcase
      end

      if (mv_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = 32'h0000_0000;
         case (mv_sel)
            `FSCR_SEL_ID: begin
               if (mv_priv) begin
                  s_d.rdata = id_word;
               end else begin
                  s_d.fault = 1'b1;
               end
            end
            `FSCR_SEL_SC: begin
               if (sc_ok) begin
                  s_d.rdata = s_q.sc;
               end else begin
                  s_d.fault = 1'b1;
               end
            end
            `FSCR_SEL_EN: begin
               if (mv_priv) begin
                  s_d.rdata = {1'b0, s_q.unit_en, s_q.vtrap, 29'h0000_0000};
               end else begin
                  s_d.fault = 1'b1;
               end
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      if (cmp_valid) begin
         s_d.sc[`FSCR_B_LT]    = cmp_lt & ~cmp_unord;
         s_d.sc[`FSCR_B_EQ]    = cmp_eq & ~cmp_unord;
         s_d.sc[`FSCR_B_CARRY] = cmp_unord | ~cmp_lt;
         s_d.sc[`FSCR_B_UNORD] = cmp_unord;
      end

      if (exc_valid) begin
         flag_bits = flag_bits | exc_flags;
      end
      s_d.sc[`FSCR_B_DENORM]    = flag_bits[5];
      s_d.sc[`FSCR_B_INEXACT:0] = flag_bits[4:0];

      if (dp_issue) begin
         if (cnt != 3'h0) begin
            s_d.vtrap = 1'b1;
            s_d.undef = 1'b1;
         end else begin
            s_d.op_go = 1'b1;
         end
      end

      // datapath controls follow the stored fields, except SIMD flush, which is tied on
      case (fscr_round_t'(s_d.sc[`FSCR_RM_HI:`FSCR_RM_LO]))
         FSCR_RND_NEAREST: s_d.rnd_oh = 4'h1;
         FSCR_RND_PLUS:    s_d.rnd_oh = 4'h2;
         FSCR_RND_MINUS:   s_d.rnd_oh = 4'h4;
         FSCR_RND_ZERO:    s_d.rnd_oh = 4'h8;
         default:          s_d.rnd_oh = 4'h1;
      endcase
      s_d.ftz_scalar = s_d.sc[`FSCR_B_FLUSH];
      s_d.ftz_simd   = 1'b1;
      s_d.half_sel   = s_d.sc[`FSCR_B_HALF];
      s_d.dnan       = s_d.sc[`FSCR_B_DNAN];
      s_d.flags      = {s_d.sc[`FSCR_B_DENORM], s_d.sc[`FSCR_B_INEXACT:0]};

      if (rst) begin
         s_d         = '0;
         s_d.sc      = `FSCR_RESET;
         s_d.unit_en = 1'b0;
         s_d.rnd_oh  = 4'h1;
         s_d.ftz_simd = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign mv_rdata               = s_q.rdata;
   assign mv_rvalid              = s_q.rvalid;
   assign mv_fault               = s_q.fault;
   assign dp_undef               = s_q.undef;
   assign dp_go                  = s_q.op_go;
   assign round_onehot           = s_q.rnd_oh;
   assign ftz_scalar             = s_q.ftz_scalar;
   assign ftz_simd               = s_q.ftz_simd;
   assign alt_half_precision_sel = s_q.half_sel;
   assign default_nan_mode       = s_q.dnan;
   assign fp_flag_export_bus     = s_q.flags;

endmodule

/* File: fscr_host_model.sv */
/* host core model issuing one-cycle move strobes to the register bank.
   assumes the bank samples moves on ref_clk and answers one cycle later. */
`timescale 1ns/100ps
module fscr_host_model (
   // clock
   input  wire logic        ref_clk,
   // moves
   output logic             mv_rd,
   output logic             mv_wr,
   output logic [3:0]       mv_sel,
   output logic             mv_priv,
   output logic [31:0]      mv_wdata,
   input  wire logic [31:0] mv_rdata,
   input  wire logic        mv_fault
);
   initial begin
      mv_rd = 1'b0;
      mv_wr = 1'b0;
      mv_sel = 4'h0;
      mv_priv = 1'b0;
      mv_wdata = 32'h0000_0000;
   end
   // write move, data inverted once released
   task automatic wr(input logic [3:0] s, input logic [31:0] d, input logic p);
      @(posedge ref_clk) #10;
      mv_wr = 1'b1;
      mv_sel = s;
      mv_priv = p;
      mv_wdata = d;
      @(posedge ref_clk) #10;
      mv_wr = 1'b0;
      mv_wdata = ~d;
   endtask
   // read move, answer taken the cycle after
   task automatic rd(input logic [3:0] s, input logic p, output logic [31:0] d,
                     output logic f);
      @(posedge ref_clk) #10;
      mv_rd = 1'b1;
      mv_sel = s;
      mv_priv = p;
      @(posedge ref_clk) #10;
      mv_rd = 1'b0;
      d = mv_rdata;
      f = mv_fault;
   endtask
endmodule

/* File: fscr_regs_assertions.sv */
/* checker for the register bank ports.
   assumes binding to fscr_regs, one clock, synchronous reset. */
`timescale 1ns/100ps
module fscr_regs_assertions (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        mv_rd,
   input wire logic        mv_wr,
   input wire logic [3:0]  mv_sel,
   input wire logic        mv_priv,
   input wire logic [31:0] mv_rdata,
   input wire logic        mv_rvalid,
   input wire logic        mv_fault,
   input wire logic        exc_valid,
   input wire logic [5:0]  exc_flags,
   input wire logic        dp_issue,
   input wire logic        dp_undef,
   input wire logic        dp_go,
   input wire logic [3:0]  round_onehot,
   input wire logic        ftz_simd,
   input wire logic [5:0]  fp_flag_export_bus
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_id_user; mv_rd && mv_sel == 4'h0 && !mv_priv; endsequence
   sequence s_id_priv; mv_rd && mv_sel == 4'h0 && mv_priv; endsequence
   property p_rv; mv_rd |=> mv_rvalid; endproperty
   property p_norv; !mv_rd |=> !mv_rvalid; endproperty
   property p_id_user; s_id_user |=> mv_fault && mv_rdata == 32'h0000_0000; endproperty
   property p_id_val; s_id_priv |=> !mv_fault && mv_rdata == 32'h5A03_3010; endproperty
   property p_rsv; mv_rd && mv_sel == 4'h2 |=> mv_rdata == 32'h0000_0000; endproperty
   property p_simd; ftz_simd; endproperty
   property p_round; $onehot(round_onehot); endproperty
   property p_exc; exc_valid |=> (fp_flag_export_bus & $past(exc_flags)) == $past(exc_flags);
   endproperty
   property p_stick; !mv_wr |=> (fp_flag_export_bus & $past(fp_flag_export_bus))
      == $past(fp_flag_export_bus); endproperty
   property p_dp; dp_issue |=> dp_go ^ dp_undef; endproperty
   a_rv: assert property (p_rv) else $error("no read answer");
   a_norv: assert property (p_norv) else $error("stray read answer");
   a_id_user: assert property (p_id_user) else $error("user id read taken");
   a_id_val: assert property (p_id_val) else $error("id word wrong");
   a_rsv: assert property (p_rsv) else $error("reserved read not zero");
   a_simd: assert property (p_simd) else $error("simd flush off");
   a_round: assert property (p_round) else $error("rounding decode bad");
   a_exc: assert property (p_exc) else $error("flag not set");
   a_stick: assert property (p_stick) else $error("flag lost");
   a_dp: assert property (p_dp) else $error("issue outcome bad");
endmodule
bind fscr_regs fscr_regs_assertions chk_u (.ref_clk, .rst, .mv_rd, .mv_wr, .mv_sel,
   .mv_priv, .mv_rdata, .mv_rvalid, .mv_fault, .exc_valid, .exc_flags, .dp_issue,
   .dp_undef, .dp_go, .round_onehot, .ftz_simd, .fp_flag_export_bus);

/* File: tb.sv */
/* self-checking bench for the register bank.
   assumes fscr_host_model drives the moves. */
`timescale 1ns/100ps
module tb;
   import fscr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cmp_valid = 1'b0, cmp_lt = 1'b0, cmp_eq = 1'b0, cmp_unord = 1'b0;
   logic exc_valid = 1'b0, dp_issue = 1'b0;
   logic [5:0] exc_flags = 6'h00;
   logic mv_rd, mv_wr, mv_priv, mv_rvalid, mv_fault, dp_undef, dp_go;
   logic ftz_scalar, ftz_simd, half_sel, dnan, f;
   logic [3:0] mv_sel, round_onehot;
   logic [5:0] exp_bus;
   logic [31:0] mv_wdata, mv_rdata, d;
   int errors = 0;
   int comparisons = 0;
   always #50 ref_clk = ~ref_clk;
   fscr_host_model host_u (.ref_clk(ref_clk), .mv_rd(mv_rd), .mv_wr(mv_wr),
      .mv_sel(mv_sel), .mv_priv(mv_priv), .mv_wdata(mv_wdata), .mv_rdata(mv_rdata),
      .mv_fault(mv_fault));
   fscr_regs dut_u (.ref_clk(ref_clk), .rst(rst), .mv_rd(mv_rd), .mv_wr(mv_wr),
      .mv_sel(mv_sel), .mv_priv(mv_priv), .mv_wdata(mv_wdata), .mv_rdata(mv_rdata),
      .mv_rvalid(mv_rvalid), .mv_fault(mv_fault), .cmp_valid(cmp_valid), .cmp_lt(cmp_lt),
      .cmp_eq(cmp_eq), .cmp_unord(cmp_unord), .exc_valid(exc_valid), .exc_flags(exc_flags),
      .dp_issue(dp_issue), .dp_undef(dp_undef), .dp_go(dp_go), .round_onehot(round_onehot),
      .ftz_scalar(ftz_scalar), .ftz_simd(ftz_simd), .alt_half_precision_sel(half_sel),
      .default_nan_mode(dnan), .fp_flag_export_bus(exp_bus));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmpt(input logic l, input logic e, input logic u, input logic [3:0] x);
      @(posedge ref_clk) #10;
      {cmp_valid, cmp_lt, cmp_eq, cmp_unord} = {1'b1, l, e, u};
      @(posedge ref_clk) #10;
      cmp_valid = 1'b0;
      host_u.rd(4'h1, 1'b0, d, f);
      check(32'(d[31:28]), 32'(x));
   endtask
   task automatic dpt(input logic [1:0] x);
      @(posedge ref_clk) #10;
      dp_issue = 1'b1;
      @(posedge ref_clk) #10;
      dp_issue = 1'b0;
      check(32'({dp_go, dp_undef}), 32'(x));
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      #10 rst = 1'b0;
      check(32'({round_onehot, ftz_simd}), 32'h0000_0003);
      host_u.rd(4'h1, 1'b1, d, f);
      check(32'(f), 32'h0000_0001);
      host_u.rd(4'h0, 1'b0, d, f);
      check(32'(f), 32'h0000_0001);
      host_u.wr(4'h8, 32'h4000_0000, 1'b1);
      host_u.wr(4'h0, 32'hFFFF_FFFF, 1'b1);
      host_u.rd(4'h0, 1'b1, d, f);
      check(d, 32'h5A03_3010);
      host_u.wr(4'h1, 32'hFFFF_FFFF, 1'b0);
      check(32'({half_sel, dnan, ftz_scalar}), 32'h0000_0007);
      host_u.rd(4'h1, 1'b0, d, f);
      check(d, 32'hF7F7_009F);
      host_u.rd(4'h2, 1'b1, d, f);
      check(d, 32'h0000_0000);
      $display("test access done");
      for (int i = 0; i < 4; i++) begin
         host_u.wr(4'h1, 32'(i) << 22, 1'b0);
         check(32'(round_onehot), 32'h0000_0001 << i);
      end
      dpt(2'h2);
      host_u.wr(4'h1, 32'h0001_0000, 1'b0);
      dpt(2'h1);
      host_u.rd(4'h8, 1'b1, d, f);
      check(d, 32'h6000_0000);
      host_u.wr(4'h1, 32'h0000_0000, 1'b0);
      $display("test control done");
      cmpt(1'b1, 1'b0, 1'b0, 4'h8);
      cmpt(1'b0, 1'b1, 1'b0, 4'h6);
      cmpt(1'b0, 1'b0, 1'b0, 4'h2);
      cmpt(1'b1, 1'b1, 1'b1, 4'h3);
      @(posedge ref_clk) #10;
      {exc_valid, exc_flags} = 7'h7F;
      @(posedge ref_clk) #10;
      exc_valid = 1'b0;
      exc_flags = 6'h00;
      repeat (3) @(posedge ref_clk);
      check(32'(exp_bus), 32'h0000_003F);
      host_u.rd(4'h1, 1'b0, d, f);
      check(32'(d[7:0]), 32'h0000_009F);
      host_u.wr(4'h1, 32'h0000_0000, 1'b0);
      check(32'(exp_bus), 32'h0000_0000);
      $display("test flags done");
      print_verdict();
   end
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
endmodule
